// >>> pkg/lcc_pkg.sv
// package: instruction codes, operand carrier and result types for the unit
package lcc_pkg;

  localparam int LCC_OPW = 9;
  localparam int LCC_DW = 32;
  localparam int LCC_HW = 16;

  // bitwise-test contacts
  localparam logic [8:0] LCC_OP_LD_AND = 9'h0D7;
  localparam logic [8:0] LCC_OP_AND_TAND = 9'h0DA;
  localparam logic [8:0] LCC_OP_AND_TXOR = 9'h0DC;
  localparam logic [8:0] LCC_OP_OR_TAND = 9'h0DD;
  localparam logic [8:0] LCC_OP_OR_TXOR = 9'h0DF;
  // relational contact families, base code is the equal relation
  localparam logic [8:0] LCC_OP_LD_CMP = 9'h0E0;
  localparam logic [8:0] LCC_OP_LD_CMP_END = 9'h0E6;
  localparam logic [8:0] LCC_OP_AND_CMP = 9'h0E8;
  localparam logic [8:0] LCC_OP_AND_CMP_END = 9'h0EE;
  localparam logic [8:0] LCC_OP_OR_CMP = 9'h0F0;
  localparam logic [8:0] LCC_OP_OR_CMP_END = 9'h0F6;
  localparam logic [8:0] LCC_OP_FLD_CMP = 9'h113;
  localparam logic [8:0] LCC_OP_FLD_CMP_END = 9'h118;
  // offset inside a family that carries no relation
  localparam logic [2:0] LCC_REL_HOLE = 3'h3;

  // relation index inside an integer family (offset from base)
  localparam logic [2:0] LCC_REL_EQ = 3'h0;
  localparam logic [2:0] LCC_REL_GT = 3'h1;
  localparam logic [2:0] LCC_REL_LT = 3'h2;
  localparam logic [2:0] LCC_REL_NE = 3'h4;
  localparam logic [2:0] LCC_REL_LE = 3'h5;
  localparam logic [2:0] LCC_REL_GE = 3'h6;

  localparam logic LCC_RUNG_RST = 1'b0;

  typedef enum logic [1:0] {
    LCC_COMB_LOAD,
    LCC_COMB_SERIES,
    LCC_COMB_PARALLEL,
    LCC_COMB_NONE
  } lcc_comb_t;

  typedef struct packed {
    logic [8:0] code;
    logic dword;
    logic [31:0] src1;
    logic [31:0] src2;
  } lcc_instr_t;

  typedef struct packed {
    logic rung;
    logic contact;
    logic illegal;
  } lcc_result_t;

endpackage

// >>> design/lcc_int_rel.sv
`timescale 1ns/1ps
// signed integer relation evaluator, 16 or 32 bit operands
module lcc_int_rel
  import lcc_pkg::*;
(
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  input wire logic dword,
  input wire logic [2:0] rel,
  output logic hit
);
  wire logic signed [31:0] a;
  wire logic signed [31:0] b;
  wire logic eq;
  wire logic lt;

  // word form sign-extends the low word; pair is low word first
  assign a = dword ? $signed(src1) : 32'($signed(src1[15:0]));
  assign b = dword ? $signed(src2) : 32'($signed(src2[15:0]));
  assign eq = (a == b);
  assign lt = (a < b);

  always_comb
  begin
    if (rel == LCC_REL_EQ) hit = eq;
    else if (rel == LCC_REL_GT) hit = !lt && !eq;
    else if (rel == LCC_REL_LT) hit = lt;
    else if (rel == LCC_REL_NE) hit = !eq;
    else if (rel == LCC_REL_LE) hit = lt || eq;
    else hit = !lt;
  end
endmodule

// >>> design/lcc_flt_rel.sv
`timescale 1ns/1ps
// single precision relation evaluator
module lcc_flt_rel
  import lcc_pkg::*;
(
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  input wire logic [2:0] rel,
  output logic hit
);
  wire logic s1;
  wire logic s2;
  wire logic z1;
  wire logic z2;
  wire logic nan;
  wire logic eq;
  wire logic lt;

  assign s1 = src1[31];
  assign s2 = src2[31];
  assign z1 = (src1[30:0] == 31'h00000000);
  assign z2 = (src2[30:0] == 31'h00000000);
  // nan makes every relation false except unequal
  assign nan = (&src1[30:23] && |src1[22:0]) ||
               (&src2[30:23] && |src2[22:0]);
  // plus and minus zero compare equal
  assign eq = !nan && ((z1 && z2) || (src1 == src2));
  assign lt = !nan && !eq &&
    ((s1 && !s2) ||
     (!s1 && !s2 && (src1[30:0] < src2[30:0])) ||
     (s1 && s2 && (src1[30:0] > src2[30:0])));

  always_comb
  begin
    if (rel == LCC_REL_EQ) hit = eq;
    else if (rel == LCC_REL_GT) hit = !nan && !lt && !eq;
    else if (rel == LCC_REL_LT) hit = lt;
    else if (rel == LCC_REL_NE) hit = !eq;
    else if (rel == LCC_REL_LE) hit = lt || eq;
    else hit = !nan && !lt;
  end
endmodule

// >>> design/lcc_contact_unit.sv
`timescale 1ns/1ps
// ladder contact compare unit: bitwise test, integer and float compares
module lcc_contact_unit
  import lcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire lcc_instr_t instr,
  output lcc_result_t result,
  output logic result_valid
);
  wire logic [8:0] code;
  wire logic [31:0] s1;
  wire logic [31:0] s2;
  wire logic [31:0] band;
  wire logic [31:0] bor;
  wire logic [31:0] bxor;
  wire logic [31:0] bsel;
  wire logic [31:0] bmask;
  wire logic is_ld_bit;
  wire logic is_ser_bit;
  wire logic is_par_bit;
  wire logic is_bit;
  wire logic [2:0] bit_off;
  wire logic [1:0] bit_op;
  wire logic bit_hit;
  wire logic in_ld;
  wire logic in_ser;
  wire logic in_par;
  wire logic in_flt;
  wire logic [2:0] rel;
  wire logic hole;
  wire logic int_hit;
  wire logic flt_hit;
  wire logic contact;
  lcc_comb_t comb;
  logic rung_q;
  logic rung_d;
  lcc_result_t result_q;
  lcc_result_t result_d;
  logic valid_q;

  // offset of a code from a family base, cut to the relation index
  function automatic logic [2:0] rel_of(input logic [8:0] c,
                                        input logic [8:0] base);
    logic [8:0] diff;
    diff = c - base;
    return diff[2:0];
  endfunction

  function automatic logic in_range(input logic [8:0] c,
                                    input logic [8:0] lo,
                                    input logic [8:0] hi);
    return (c >= lo) && (c <= hi);
  endfunction

  assign code = instr.code;
  assign s1 = instr.src1;
  assign s2 = instr.src2;

  // bitwise tests
  assign is_ld_bit = in_range(code, LCC_OP_LD_AND, LCC_OP_LD_AND + 9'h002);
  assign is_ser_bit = in_range(code, LCC_OP_AND_TAND, LCC_OP_AND_TXOR);
  assign is_par_bit = in_range(code, LCC_OP_OR_TAND, LCC_OP_OR_TXOR);
  assign is_bit = is_ld_bit || is_ser_bit || is_par_bit;
  assign bit_off = is_ld_bit ? rel_of(code, LCC_OP_LD_AND) :
                   is_ser_bit ? rel_of(code, LCC_OP_AND_TAND) :
                   rel_of(code, LCC_OP_OR_TAND);
  assign bit_op = bit_off[1:0];
  assign band = s1 & s2;
  assign bor = s1 | s2;
  assign bxor = s1 ^ s2;
  assign bsel = (bit_op == 2'h0) ? band :
                (bit_op == 2'h1) ? bor : bxor;
  // word form only looks at the low word
  assign bmask = instr.dword ? 32'hFFFFFFFF : 32'h0000FFFF;
  assign bit_hit = |(bsel & bmask);

  // relational families
  assign in_ld = in_range(code, LCC_OP_LD_CMP, LCC_OP_LD_CMP_END);
  assign in_ser = in_range(code, LCC_OP_AND_CMP, LCC_OP_AND_CMP_END);
  assign in_par = in_range(code, LCC_OP_OR_CMP, LCC_OP_OR_CMP_END);
  assign in_flt = in_range(code, LCC_OP_FLD_CMP, LCC_OP_FLD_CMP_END);
  assign rel = in_ld ? rel_of(code, LCC_OP_LD_CMP) :
               in_ser ? rel_of(code, LCC_OP_AND_CMP) :
               in_par ? rel_of(code, LCC_OP_OR_CMP) : 3'h0;
  assign hole = (in_ld || in_ser || in_par) && (rel == LCC_REL_HOLE);

  // float codes skip the hole, so remap 278..280 onto ne/le/ge
  wire logic [2:0] frel_raw;
  wire logic [2:0] frel;
  assign frel_raw = rel_of(code, LCC_OP_FLD_CMP);
  assign frel = (frel_raw >= LCC_REL_HOLE) ? frel_raw + 3'h1 : frel_raw;

  lcc_int_rel u_int_rel (
    .src1(s1),
    .src2(s2),
    .dword(instr.dword),
    .rel(rel),
    .hit(int_hit)
  );

  // float operands are always a full 32-bit pair or constant
  lcc_flt_rel u_flt_rel (
    .src1(s1),
    .src2(s2),
    .rel(frel),
    .hit(flt_hit)
  );

  assign contact = is_bit ? bit_hit : (in_flt ? flt_hit : int_hit);

  assign comb = (is_ld_bit || in_ld || in_flt) ? LCC_COMB_LOAD :
                (is_ser_bit || in_ser) ? LCC_COMB_SERIES :
                (is_par_bit || in_par) ? LCC_COMB_PARALLEL :
                LCC_COMB_NONE;

  always_comb
  begin
    rung_d = rung_q;
    result_d = result_q;
    if (instr_valid)
    begin
      result_d.illegal = hole || (comb == LCC_COMB_NONE);
      // unknown codes must not show a stray contact
      result_d.contact = contact && !hole && (comb != LCC_COMB_NONE);
      if (hole)
        rung_d = rung_q;
      else
      begin
        case (comb)
          LCC_COMB_LOAD: rung_d = contact;
          LCC_COMB_SERIES: rung_d = rung_q & contact;
          LCC_COMB_PARALLEL: rung_d = rung_q | contact;
          default: rung_d = rung_q;
        endcase
      end
      result_d.rung = rung_d;
    end
  end

  // one instruction per cycle; result appears on the next edge
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rung_q <= LCC_RUNG_RST;
      result_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      rung_q <= rung_d;
      result_q <= result_d;
      valid_q <= instr_valid;
    end
  end

  assign result = result_q;
  assign result_valid = valid_q;
endmodule

// >>> testbench/lcc_contact_monitor.sv
// port checker for the contact unit
`timescale 1ns/1ps
module lcc_contact_monitor
  import lcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire lcc_instr_t instr,
  input wire lcc_result_t result,
  input wire logic result_valid
);
  wire logic v = instr_valid;
  wire logic [8:0] c = instr.code;
  wire logic ser = c inside {[9'h0E8:9'h0EE]} && c != 9'h0EB;
  wire logic par = c inside {[9'h0DD:9'h0DF], [9'h0F0:9'h0F6]} &&
    c != 9'h0F3;
  wire logic ill = c inside {9'h0E3, 9'h0EB, 9'h0F3};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_answer_next: assert property (v |=> result_valid)
    else $error("no answer one cycle after issue");
  a_no_stray: assert property (!v |=> !result_valid)
    else $error("answer without issue");
  a_idle_hold: assert property (!v |=> $stable(result))
    else $error("result moved while idle");
  a_bitwise_zero: assert property (v && c == 9'h0DA &&
    (instr.src1 & instr.src2) == 0 |=> !result.contact && !result.rung)
    else $error("zero and test not inactive");
  a_series_low: assert property (v && ser && !result.rung
    |=> !result.rung) else $error("series lifted a low rung");
  a_parallel_high: assert property (v && par && result.rung
    |=> result.rung) else $error("parallel dropped a high rung");
  a_illegal_keep: assert property (v && ill |=> result.illegal &&
    !result.contact && $stable(result.rung))
    else $error("unassigned code mishandled");
  a_load_equal: assert property (v && c == 9'h0E0 &&
    !instr.dword && instr.src1[15:0] == instr.src2[15:0]
    |=> result.contact && result.rung) else $error("equal load missed");
  a_signed_gt: assert property (v && c == 9'h0E1 && instr.dword &&
    $signed(instr.src1) > $signed(instr.src2) |=> result.contact)
    else $error("signed greater missed");
  c_series: cover property (v && ser && result.rung);
  c_parallel: cover property (v && par && !result.rung);
  c_illegal: cover property (v && ill);
endmodule
bind lcc_contact_unit lcc_contact_monitor u_mon (.mclk(mclk), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .result(result),
  .result_valid(result_valid));

// >>> testbench/lcc_seq_model.sv
// sequencer model presenting instructions to the unit
`timescale 1ns/1ps
module lcc_seq_model
  import lcc_pkg::*;
(
  input wire logic mclk,
  output logic instr_valid,
  output lcc_instr_t instr
);
  initial
  begin
    instr_valid = 1'b0;
    instr = '0;
  end
  task automatic issue(input lcc_instr_t i);
    instr_valid = 1'b1;
    instr = i;
    @(posedge mclk);
    #1;
  endtask
  // empty slot: operands are not held, so they change
  task automatic idle();
    instr_valid = 1'b0;
    instr = ~instr;
    @(posedge mclk);
    #1;
  endtask
endmodule

// >>> testbench/test_ladder_contact_compare_unit.sv
// self-checking bench for the contact unit
`timescale 1ns/1ps
module test_ladder_contact_compare_unit
  import lcc_pkg::*;
();
  logic mclk;
  logic rst;
  logic instr_valid;
  lcc_instr_t instr;
  lcc_result_t result;
  logic result_valid;
  int fails;
  int check_count;
  int rung;
  int s;
  logic [2:0] exp_q[$];
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  lcc_contact_unit dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .result(result), .result_valid(result_valid));
  lcc_seq_model seq (.mclk(mclk), .instr_valid(instr_valid), .instr(instr));
  function automatic bit rel(int o, real p, real q);
    case (o)
      0: return p == q;
      1: return p > q;
      2: return p < q;
      4: return p != q;
      5: return p <= q;
      default: return p >= q;
    endcase
  endfunction
  // reference: returns rung, contact, illegal and advances the rung
  function automatic logic [2:0] mdl(lcc_instr_t t);
    int c;
    int o;
    int g;
    int x;
    int y;
    bit h;
    c = t.code;
    x = t.dword ? int'(t.src1) : int'($signed(t.src1[15:0]));
    y = t.dword ? int'(t.src2) : int'($signed(t.src2[15:0]));
    o = (c - 224) % 8;
    g = (c - 224) / 8;
    if (c >= 215 && c <= 223)
    begin
      o = (c - 215) % 3;
      g = (c - 215) / 3;
      h = o == 0 ? (x & y) != 0 : o == 1 ? (x | y) != 0 : (x ^ y) != 0;
    end
    else if (c >= 275 && c <= 280)
    begin
      g = 0;
      h = rel(c - 275 + (c > 277), $bitstoshortreal(t.src1),
        $bitstoshortreal(t.src2));
    end
    else if (c >= 224 && c <= 246 && !(o inside {3, 7}))
      h = rel(o, x, y);
    else
      return {rung[0], 2'b01};
    rung = g == 0 ? h : g == 1 ? rung & h : rung | h;
    return {rung[0], h, 1'b0};
  endfunction
  task automatic check(logic [2:0] e, logic [2:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: expected %0h got %0h", $time, e, g);
    end
  endtask
  task automatic send(int c, bit d, logic [31:0] a, logic [31:0] b);
    lcc_instr_t i;
    i = '{9'(c), d, a, b};
    exp_q.push_back(mdl(i));
    seq.issue(i);
  endtask
  function automatic logic [31:0] pick(int c);
    int k;
    k = int'($urandom % 5) - 2;
    if (c >= 275)
      return $shortrealtobits(shortreal'(k));
    return $urandom % 2 ? $urandom : 32'(k);
  endfunction
  task automatic run(int n);
    int c;
    repeat (n)
    begin
      c = 215 + $urandom % 66;
      if ($urandom % 8 == 0)
        seq.idle();
      send(c, $urandom % 2, pick(c), pick(c));
    end
    seq.idle();
    seq.idle();
  endtask
  always @(posedge mclk)
  begin
    #1;
    if (result_valid === 1'b1)
      check(exp_q.pop_front(), result);
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    fails = 0;
    check_count = 0;
    rung = 0;
    s = $urandom(32'h0831);
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    send(224, 0, 5, 5);
    send(233, 0, 32'hFFFF, 0);
    send(225, 1, 32'hFFFFFFE2, 32'hFFFFFFE1);
    send(219, 1, 32'h10000, 0);
    send(219, 0, 32'h10000, 0);
    send(279, 1, $shortrealtobits(-1.0), $shortrealtobits(1.2));
    run(3000);
    rst = 1'b1;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    rung = 0;
    check(3'h0, result);
    run(3000);
    summarize();
  end
  // about 6800 cycles of 4 ns are expected; allow almost four times that
  initial
  begin
    #100000;
    fails++;
    summarize();
  end
endmodule
